// *** lcdc_core.v ***
// led channel dimming core: registers, undervoltage lockout, pwm timebase and 18 channels
// Function
// - main supply below lockout stops the device; recovery resumes it automatically.
// - regulated logic supply below lockout also disables; recovery resumes.
// - entering either lockout returns every register to its default value.
// - range bit selects full-scale gain 500 when 0, 165 when 1.
// - 6-bit global code scales every channel's current in 64 steps.
// - one 7-bit trim register per channel at 14h to 25h.
// - channel current is full scale times global/64 times trim/128.
// - each channel has its own 12-bit pwm generator switching its sink.
// - duty values live in a register bank from 26h to 40h.
// - pwm frequency selectable by configuration; fastest about 24 kHz.
// - 12-bit and 7+5-bit modes give duty equal to value/4096.
// - 8-bit mode uses duty bits 11..4 only, duty equals byte/256.
// - phase delay starts six groups of three channels in turn.
`timescale 1ns/100ps
`include "lcdc_defs.vh"

// register map of the block
// 00: bit0 current range, bits2:1 pwm mode, bits4:3 rate select
// 01: bits5:0 global current code
// 03: bit0 phase delay enable, on after reset
// 14..25: bits6:0 current trim of channels 1 to 18
// 26..40: duty bytes, three bytes carry the 12-bit duties of two channels
// unmapped addresses read zero; lockout returns every register to its default

module lcdc_core (
	input wire clk_sys,
	input wire rst,
	input wire vin_ok_pin,
	input wire vdd_ok_pin,
	input wire reg_wr_en,
	input wire reg_rd_en,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wr_data,
	output reg [7:0] reg_rd_data_q,
	output reg reg_rd_valid_q,
	output wire [17:0] led_output,
	output wire [233:0] channel_current_code,
	output reg [8:0] full_scale_gain_q,
	output reg current_range_select_q,
	output reg lockout_active_q
);

// divider counts are reckoned at full width, then cut to the counter width on purpose
localparam [31:0] DIV_12B_FULL = `LCDC_DIV_12B;
localparam [31:0] DIV_8B_FULL = `LCDC_DIV_8B;
localparam [31:0] DIV_75B_FULL = `LCDC_DIV_75B;
localparam [11:0] DIV_12B = DIV_12B_FULL[11:0];
localparam [11:0] DIV_8B = DIV_8B_FULL[11:0];
localparam [11:0] DIV_75B = DIV_75B_FULL[11:0];
// only the five used configuration bits are stored
localparam [7:0] CFG_RST_FULL = `LCDC_RST_CONFIG & `LCDC_CFG_USED_MASK;

////////////////////////////////////////////////////////////////////////////////
// supply good synchronisers

reg vin_meta_q;
reg vin_sync_q;
reg vdd_meta_q;
reg vdd_sync_q;
wire lockout;

// pins are asynchronous, two flops before any logic
always @(posedge clk_sys) begin
	if (rst) begin
		vin_meta_q <= 1'b0;
		vin_sync_q <= 1'b0;
		vdd_meta_q <= 1'b0;
		vdd_sync_q <= 1'b0;
	end else begin
		vin_meta_q <= vin_ok_pin;
		vin_sync_q <= vin_meta_q;
		vdd_meta_q <= vdd_ok_pin;
		vdd_sync_q <= vdd_meta_q;
	end
end

assign lockout = !vin_sync_q || !vdd_sync_q;

////////////////////////////////////////////////////////////////////////////////
// register file

reg [4:0] config_q;
reg [5:0] global_code_q;
reg phase_en_q;
reg [6:0] trim_q [0:17];
reg [7:0] duty_mem [0:26];
integer k;

wire [1:0] pwm_mode = config_q[`LCDC_CFG_MODE_HI:`LCDC_CFG_MODE_LO];
wire [1:0] freq_sel = config_q[`LCDC_CFG_FSEL_HI:`LCDC_CFG_FSEL_LO];

// address window test, shared by the trim and duty decodes
function in_range;
	input [7:0] addr;
	input [7:0] lo;
	input [7:0] hi;
	begin
		in_range = (addr >= lo) && (addr <= hi);
	end
endfunction

wire in_trim = in_range(reg_addr, `LCDC_ADDR_TRIM_FIRST, `LCDC_ADDR_TRIM_LAST);
wire in_duty = in_range(reg_addr, `LCDC_ADDR_DUTY_FIRST, `LCDC_ADDR_DUTY_LAST);
wire [7:0] trim_idx = reg_addr - `LCDC_ADDR_TRIM_FIRST;
wire [7:0] duty_idx = reg_addr - `LCDC_ADDR_DUTY_FIRST;

// writes; lockout holds every register at its default and ignores the host
always @(posedge clk_sys) begin
	if (rst || lockout) begin
		config_q <= CFG_RST_FULL[4:0];
		global_code_q <= `LCDC_RST_GLOBAL;
		phase_en_q <= `LCDC_RST_PHASE;
		for (k = 0; k < `LCDC_NUM_CH; k = k + 1) begin
			trim_q[k] <= `LCDC_RST_TRIM;
		end
		for (k = 0; k < `LCDC_NUM_DUTY_BYTES; k = k + 1) begin
			duty_mem[k] <= `LCDC_RST_DUTY;
		end
	end else if (reg_wr_en) begin
		if (reg_addr == `LCDC_ADDR_CONFIG) begin
			config_q <= reg_wr_data[4:0];
		end
		if (reg_addr == `LCDC_ADDR_GLOBAL) begin
			global_code_q <= reg_wr_data[5:0];
		end
		if (reg_addr == `LCDC_ADDR_PHASE) begin
			phase_en_q <= reg_wr_data[`LCDC_PHASE_EN_BIT];
		end
		if (in_trim) begin
			trim_q[trim_idx[4:0]] <= reg_wr_data[6:0];
		end
		if (in_duty) begin
			duty_mem[duty_idx[4:0]] <= reg_wr_data;
		end
	end
end

reg [7:0] rd_d;

// read decode; unused bits and unmapped addresses read zero
always @* begin
	rd_d = 8'h00;
	if (reg_addr == `LCDC_ADDR_CONFIG) begin
		rd_d = {3'h0, config_q};
	end else if (reg_addr == `LCDC_ADDR_GLOBAL) begin
		rd_d = {2'h0, global_code_q};
	end else if (reg_addr == `LCDC_ADDR_PHASE) begin
		rd_d = {7'h00, phase_en_q};
	end else if (in_trim) begin
		rd_d = {1'b0, trim_q[trim_idx[4:0]]};
	end else if (in_duty) begin
		rd_d = duty_mem[duty_idx[4:0]];
	end
end

// read data answers one cycle after the strobe
always @(posedge clk_sys) begin
	if (rst) begin
		reg_rd_data_q <= 8'h00;
		reg_rd_valid_q <= 1'b0;
	end else begin
		reg_rd_valid_q <= reg_rd_en;
		if (reg_rd_en) begin
			reg_rd_data_q <= rd_d;
		end
	end
end

// gain selection and status flops
always @(posedge clk_sys) begin
	if (rst) begin
		full_scale_gain_q <= `LCDC_GAIN_RANGE0;
		current_range_select_q <= 1'b0;
		lockout_active_q <= 1'b1;
	end else begin
		current_range_select_q <= config_q[`LCDC_CFG_RANGE_BIT];
		full_scale_gain_q <= config_q[`LCDC_CFG_RANGE_BIT] ? `LCDC_GAIN_RANGE1 : `LCDC_GAIN_RANGE0;
		lockout_active_q <= lockout;
	end
end

////////////////////////////////////////////////////////////////////////////////
// pwm timebase

// step divider of the selected mode, slowed by the frequency select
function [11:0] step_div;
	input [1:0] mode;
	input [1:0] fsel;
	reg [11:0] base;
	begin
		case (mode)
			`LCDC_MODE_8B: base = DIV_8B;
			`LCDC_MODE_75B: base = DIV_75B;
			default: base = DIV_12B;
		endcase
		step_div = base << fsel;
	end
endfunction

// last count of the period for the selected mode
function [11:0] period_mask;
	input [1:0] mode;
	begin
		case (mode)
			`LCDC_MODE_8B: period_mask = `LCDC_MASK_8B;
			`LCDC_MODE_75B: period_mask = `LCDC_MASK_75B;
			default: period_mask = `LCDC_MASK_12B;
		endcase
	end
endfunction

// start offset of a group in eighths of the period: 0,1,3,4,6,7
function [11:0] group_offset;
	input integer grp;
	input [1:0] mode;
	reg [11:0] eighths;
	begin
		case (grp)
			1: eighths = 12'h001;
			2: eighths = 12'h003;
			3: eighths = 12'h004;
			4: eighths = 12'h006;
			5: eighths = 12'h007;
			default: eighths = 12'h000;
		endcase
		case (mode)
			`LCDC_MODE_8B: group_offset = eighths << 5;
			`LCDC_MODE_75B: group_offset = eighths << 4;
			default: group_offset = eighths << 9;
		endcase
	end
endfunction

// timebase state; mode and rate changes take effect at the next step
reg [11:0] div_q;
reg [11:0] cnt_q;
reg [4:0] frame_q;
wire [11:0] mask = period_mask(pwm_mode);
wire step = (div_q == 12'h000);

// divider gives a one-cycle step enable; counter wraps at the period end
always @(posedge clk_sys) begin
	if (rst || lockout) begin
		div_q <= 12'h000;
		cnt_q <= 12'h000;
		frame_q <= 5'h00;
	end else begin
		if (step) begin
			div_q <= step_div(pwm_mode, freq_sel) - 12'h001;
			// a mode change can leave the count past the new end, so wrap on >=
			if (cnt_q >= mask) begin
				cnt_q <= 12'h000;
				frame_q <= frame_q + 5'h01;
			end else begin
				cnt_q <= cnt_q + 12'h001;
			end
		end else begin
			div_q <= div_q - 12'h001;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// channels

wire [11:0] grp_pos [0:5];

genvar g;
genvar i;
generate
	for (g = 0; g < 6; g = g + 1) begin : gen_grp
		// position lags by the group's delay, so group g turns on that much after group 0
		assign grp_pos[g] = phase_en_q ?
			((cnt_q - group_offset(g, pwm_mode)) & mask) : cnt_q;
	end
	for (i = 0; i < `LCDC_NUM_CH; i = i + 1) begin : gen_ch
		// packed 12-bit duty of this channel
		wire [11:0] duty;
		if (i % 2 == 0) begin : gen_even
			assign duty = {duty_mem[3 * (i / 2)], duty_mem[3 * (i / 2) + 1][7:4]};
		end else begin : gen_odd
			assign duty = {duty_mem[3 * (i / 2) + 1][3:0], duty_mem[3 * (i / 2) + 2]};
		end
		// one generator per channel, fed by its group's position
		lcdc_pwm_channel i_lcdc_pwm_channel (
			.clk_sys(clk_sys),
			.rst(rst),
			.run(!lockout),
			.mode(pwm_mode),
			.pos(grp_pos[i / 3]),
			.frame(frame_q),
			.duty(duty),
			.global_code(global_code_q),
			.trim(trim_q[i]),
			.led_on_q(led_output[i]),
			.current_code_q(channel_current_code[13 * i + 12:13 * i])
		);
	end
endgenerate

endmodule // lcdc_core

// *** lcdc_core_checker.sv ***
// assertion checker watching the ports of the led channel dimming core
`timescale 1ns/100ps
module lcdc_core_checker (
	input wire clk_sys,
	input wire rst,
	input wire vin_ok_pin,
	input wire vdd_ok_pin,
	input wire reg_wr_en,
	input wire reg_rd_en,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wr_data,
	input wire [7:0] reg_rd_data_q,
	input wire reg_rd_valid_q,
	input wire [17:0] led_output,
	input wire [233:0] channel_current_code,
	input wire [8:0] full_scale_gain_q,
	input wire current_range_select_q,
	input wire lockout_active_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	// register port answers
	chk_rd_answer: assert property (reg_rd_en |=> reg_rd_valid_q) else $error("read strobe not answered");
	chk_rd_pulse: assert property (!reg_rd_en |=> !reg_rd_valid_q) else $error("read valid without strobe");
	chk_rd_hold: assert property (!reg_rd_valid_q |-> $stable(reg_rd_data_q)) else $error("read data moved");
	// gain and range select both follow the range bit one cycle later; judge only once it is steady
	chk_gain_range: assert property ($stable(current_range_select_q) |->
		full_scale_gain_q == (current_range_select_q ? 9'h0a5 : 9'h1f4)) else $error("gain wrong for range");
	// supply faults pass two sync flops before lockout shows
	chk_vin_lock: assert property ($fell(vin_ok_pin) |-> ##[1:4] lockout_active_q) else $error("no main lockout");
	chk_vdd_lock: assert property ($fell(vdd_ok_pin) |-> ##[1:4] lockout_active_q) else $error("no logic lockout");
	chk_lock_dark: assert property (lockout_active_q [*3] |->
		led_output == 18'h00000 && channel_current_code == 234'h0) else $error("outputs live in lockout");
	chk_lock_recover: assert property ((vin_ok_pin && vdd_ok_pin) [*6] |-> !lockout_active_q)
		else $error("lockout did not end");
	cover property (reg_rd_valid_q && reg_rd_data_q == 8'h3f);
	cover property ($rose(lockout_active_q));
	cover property (led_output[0] && !led_output[1]);
endmodule // lcdc_core_checker

bind lcdc_core lcdc_core_checker i_lcdc_core_checker (.*);

// *** lcdc_defs.vh ***
// offsets, field positions, reset values and timing counts of the led channel dimming core
`ifndef LCDC_DEFS_VH
`define LCDC_DEFS_VH

// register byte offsets
`define LCDC_ADDR_CONFIG 8'h00
`define LCDC_ADDR_GLOBAL 8'h01
`define LCDC_ADDR_PHASE 8'h03
`define LCDC_ADDR_TRIM_FIRST 8'h14
`define LCDC_ADDR_TRIM_LAST 8'h25
`define LCDC_ADDR_DUTY_FIRST 8'h26
`define LCDC_ADDR_DUTY_LAST 8'h40

// configuration field positions
`define LCDC_CFG_RANGE_BIT 0
`define LCDC_CFG_MODE_LO 1
`define LCDC_CFG_MODE_HI 2
`define LCDC_CFG_FSEL_LO 3
`define LCDC_CFG_FSEL_HI 4
`define LCDC_CFG_USED_MASK 8'h1f
`define LCDC_PHASE_EN_BIT 0

// pwm modes
`define LCDC_MODE_12B 2'h0
`define LCDC_MODE_75B 2'h1
`define LCDC_MODE_8B 2'h2

// reset values
`define LCDC_RST_CONFIG 8'h00
`define LCDC_RST_GLOBAL 6'h00
`define LCDC_RST_PHASE 1'h1
`define LCDC_RST_TRIM 7'h00
`define LCDC_RST_DUTY 8'h00

// full scale gains
`define LCDC_GAIN_RANGE0 9'h1f4
`define LCDC_GAIN_RANGE1 9'h0a5

// counts
`define LCDC_NUM_CH 18
`define LCDC_NUM_DUTY_BYTES 27
`define LCDC_MASK_12B 12'hfff
`define LCDC_MASK_8B 12'h0ff
`define LCDC_MASK_75B 12'h07f

// timing: clock rate and pwm cycle rates in hertz, clocks per step
`define LCDC_CLK_HZ 200000000
`define LCDC_PWM12_HZ 244
`define LCDC_PWM8_HZ 24000
`define LCDC_PWM75_HZ 24000
`define LCDC_DIV_12B (`LCDC_CLK_HZ / (`LCDC_PWM12_HZ * 4096))
`define LCDC_DIV_8B (`LCDC_CLK_HZ / (`LCDC_PWM8_HZ * 256))
`define LCDC_DIV_75B (`LCDC_CLK_HZ / (`LCDC_PWM75_HZ * 128))

`endif

// *** lcdc_host_model.sv ***
// host model driving the register port of the dimming core
`timescale 1ns/100ps
module lcdc_host_model (
	input wire clk_sys,
	output reg reg_wr_en = 1'b0,
	output reg reg_rd_en = 1'b0,
	output reg [7:0] reg_addr = 8'h00,
	output reg [7:0] reg_wr_data = 8'h00,
	input wire [7:0] reg_rd_data_q,
	input wire reg_rd_valid_q
);
	////////////////////////////////////////
	// one byte write; idle cycle after so the strobe is never set twice in one step
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_en <= 1'b1;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
		reg_wr_data <= ~d; // released data is scrambled, not held
		@(posedge clk_sys);
	endtask
	// one read; answer is taken in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		#1;
		d = reg_rd_data_q;
		v = reg_rd_valid_q;
		@(posedge clk_sys);
	endtask
endmodule // lcdc_host_model

// *** lcdc_pwm_channel.v ***
// one pwm generator and current code of a single led channel
`timescale 1ns/100ps
`include "lcdc_defs.vh"

module lcdc_pwm_channel (
	input wire clk_sys,
	input wire rst,
	input wire run,
	input wire [1:0] mode,
	input wire [11:0] pos,
	input wire [4:0] frame,
	input wire [11:0] duty,
	input wire [5:0] global_code,
	input wire [6:0] trim,
	output reg led_on_q,
	output reg [12:0] current_code_q
);

reg led_on_d;
reg [7:0] thr;

// compare position against duty for the selected resolution
always @* begin
	thr = {1'b0, duty[11:5]};
	case (mode)
		`LCDC_MODE_8B: begin
			led_on_d = pos[7:0] < duty[11:4];
		end
		`LCDC_MODE_75B: begin
			// 5 low bits add one step in that many of 32 cycles
			thr = {1'b0, duty[11:5]} + {7'h00, (frame < duty[4:0])};
			led_on_d = {1'b0, pos[6:0]} < thr;
		end
		default: begin
			led_on_d = pos < duty;
		end
	endcase
end

// registered outputs, forced off while not running
always @(posedge clk_sys) begin
	if (rst || !run) begin
		led_on_q <= 1'b0;
		current_code_q <= 13'h0000;
	end else begin
		led_on_q <= led_on_d;
		current_code_q <= global_code * trim;
	end
end

endmodule // lcdc_pwm_channel

// *** tb_lcdc_core.sv ***
// self-checking testbench of the led channel dimming core
`timescale 1ns/100ps
module tb_lcdc_core;
	reg clk_sys = 1'b0;
	reg rst = 1'b1;
	reg vin_ok_pin = 1'b1;
	reg vdd_ok_pin = 1'b1;
	wire reg_wr_en, reg_rd_en, reg_rd_valid_q, current_range_select_q, lockout_active_q;
	wire [7:0] reg_addr, reg_wr_data, reg_rd_data_q;
	wire [17:0] led_output;
	wire [233:0] channel_current_code;
	wire [8:0] full_scale_gain_q;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int on1, on2;
	int gap;
	logic [7:0] rd_d;
	logic rd_v;
	always #2.5 clk_sys = ~clk_sys;
	lcdc_core i_lcdc_core (.*);
	lcdc_host_model i_lcdc_host_model (.*);
	////////////////////////////////////////
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		i_lcdc_host_model.wr(a, d);
	endtask
	task rc(input logic [7:0] a, input logic [7:0] e);
		i_lcdc_host_model.rd(a, rd_d, rd_v);
		chk("read valid", 16'h0001, {15'h0, rd_v});
		chk("read data", {8'h00, e}, {8'h00, rd_d});
	endtask
	// on cycles of channels 1 and 2, and the rise gap from channel 1 to channel 4
	task measure(input int len);
		int p1, p4, t1, t4;
		on1 = 0;
		on2 = 0;
		t1 = 0;
		t4 = 0;
		p1 = led_output[0];
		p4 = led_output[3];
		for (int n = 0; n < len; n++) begin
			@(posedge clk_sys);
			#1;
			if (led_output[0] && !p1) t1 = n;
			if (led_output[3] && !p4) t4 = n;
			p1 = led_output[0];
			p4 = led_output[3];
			on1 += led_output[0];
			on2 += led_output[1];
		end
		gap = (t4 - t1 + len) % len;
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard: the tests need about 26000 cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rc(8'h00, 8'h00);
		rc(8'h03, 8'h01);
		rc(8'h14, 8'h00);
		rc(8'h40, 8'h00);
		chk("gain", 16'h01f4, {7'h0, full_scale_gain_q});
		$display("test defaults done");
		wr(8'h01, 8'hff);
		rc(8'h01, 8'h3f);
		wr(8'h14, 8'hff);
		rc(8'h14, 8'h7f);
		wr(8'h25, 8'h55);
		rc(8'h25, 8'h55);
		wr(8'h15, 8'h00);
		wr(8'h02, 8'hff);
		rc(8'h02, 8'h00);
		wr(8'h00, 8'h01);
		rc(8'h00, 8'h01);
		chk("range", 16'h0001, {15'h0, current_range_select_q});
		chk("gain", 16'h00a5, {7'h0, full_scale_gain_q});
		chk("code ch1", 16'h1f41, {3'h0, channel_current_code[12:0]});
		chk("code ch2", 16'h0000, {3'h0, channel_current_code[25:13]});
		chk("code ch18", 16'h14eb, {3'h0, channel_current_code[233:221]});
		$display("test registers done");
		// 8-bit mode, phase on: low nibble of channel 1 set but must be ignored
		wr(8'h00, 8'h04);
		wr(8'h26, 8'h80);
		wr(8'h27, 8'hf0);
		wr(8'h28, 8'h00);
		wr(8'h2a, 8'h08);
		// the old mode's step of up to 200 clocks must run out before measuring
		repeat (300) @(posedge clk_sys);
		// exactly one period, so the phase offset cannot change the count
		measure(8192);
		chk("on time ch1", 16'h1000, on1[15:0]);
		chk("on time ch2", 16'h0000, on2[15:0]);
		chk("group delay", 16'h0400, gap[15:0]);
		$display("test pwm 8-bit done");
		// 7+5 mode at half rate, phase off: quarter duty, groups start together
		wr(8'h00, 8'h0a);
		wr(8'h03, 8'h00);
		wr(8'h26, 8'h40);
		wr(8'h27, 8'h00);
		wr(8'h2a, 8'h04);
		repeat (300) @(posedge clk_sys);
		measure(16640);
		chk("on time ch1", 16'h1040, on1[15:0]);
		chk("on time ch2", 16'h0000, on2[15:0]);
		chk("group delay", 16'h0000, gap[15:0]);
		$display("test pwm 7+5 done");
		@(posedge clk_sys);
		vin_ok_pin <= 1'b0;
		repeat (5) @(posedge clk_sys);
		vin_ok_pin <= 1'b1;
		#1;
		chk("lockout", 16'h0001, {15'h0, lockout_active_q});
		repeat (8) @(posedge clk_sys);
		rc(8'h01, 8'h00);
		chk("lockout", 16'h0000, {15'h0, lockout_active_q});
		chk("code ch1", 16'h0000, {3'h0, channel_current_code[12:0]});
		wr(8'h01, 8'h2a);
		vdd_ok_pin <= 1'b0;
		repeat (5) @(posedge clk_sys);
		wr(8'h14, 8'h11);
		vdd_ok_pin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rc(8'h01, 8'h00);
		rc(8'h14, 8'h00);
		$display("test lockout done");
		print_verdict;
	end
endmodule // tb_lcdc_core
